// ### src/lut_cell_map.vh
/*
  Constants for the table cell cluster: widths, mode codes and reset values.
  Assumes inclusion by bare name from the cluster and cell modules.
*/
`ifndef LUT_CELL_MAP_VH
`define LUT_CELL_MAP_VH

// ----------------------------------------------------------------------------
// Cell geometry
// ----------------------------------------------------------------------------
`define LUT_IN_W 4
`define LUT_DEPTH 16
`define CLUSTER_CELLS 4
`define CHAIN_DEPTH 64
`define CHAIN_TAP_W 6

// ----------------------------------------------------------------------------
// Cell mode codes
// ----------------------------------------------------------------------------
`define MODE_W 2
`define MODE_LOGIC 2'h0
`define MODE_RAM 2'h1
`define MODE_SHIFT 2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OUT_RST 1'h0
`define BUF_CNT_RST 2'h0

`endif

// ### src/lut_cell.v
/*
  One four-input table cell: logic/ROM, writable 16x1 memory with a second
  read address, or 1..16 stage shift register with chain in and chain out.
  Assumes a single clock; contents preset by the INIT parameter.
*/
`include "lut_cell_map.vh"

module lut_cell #(
  parameter [15:0] INIT = 16'h0000,
  parameter WRITABLE = 1
) (
  input wire i_ref_clk,
  input wire [1:0] i_mode,
  input wire [3:0] i_lut_inputs,
  input wire [3:0] i_read2_addr,
  input wire i_we,
  input wire i_data,
  input wire i_chain_serial_in,
  output wire o_out,
  output wire o_out2,
  output wire o_chain_serial_out
);

  reg [15:0] mem_r = INIT;
  wire wr_ok;

  // Right-hand cells ignore writes and shifts, staying preset storage
  assign wr_ok = (WRITABLE != 0) && i_we;

  always @(posedge i_ref_clk) begin
    if (wr_ok && i_mode == `MODE_RAM) begin
      mem_r[i_lut_inputs] <= i_data;
    end else if (wr_ok && i_mode == `MODE_SHIFT) begin
      mem_r <= {mem_r[14:0], i_chain_serial_in};
    end
  end

  assign o_out = mem_r[i_lut_inputs];
  assign o_out2 = mem_r[i_read2_addr];
  assign o_chain_serial_out = mem_r[15];

endmodule // lut_cell

// ### src/lut_cluster.v
/*
  A logic cluster of eight table cells: four left-hand cells with memory and
  shift modes, four right-hand cells with logic and preset storage only.
  Wide multiplexers join cells; the left cells chain into a 64-stage delay.
  Outputs are registered; o_out_data passes a two-entry buffer toward the receiver.
  Assumes inputs synchronous to i_ref_clk and contents preset at build time.
*/
// Operation
// - Each cell maps four inputs to one output, any Boolean function.
// - Wide multiplexers join cells into functions of more than four inputs.
// - Any cell can act as preset read-only memory.
// - Only left-hand cells write or shift; right-hand cells logic and ROM.
// - A left-hand memory cell holds sixteen one-bit locations.
// - Left cells combine into a deeper 64x1 memory.
// - Dual-port pairing gives a second independent read address.
// - A shift cell delays serial input by one to sixteen cycles.
// - Four left cells chain into a delay of up to sixty-four cycles.
// - Chain in and chain out ports extend cascades across clusters.
`include "lut_cell_map.vh"

module lut_cluster #(
  parameter [63:0] LEFT_INIT = 64'h0000_0000_0000_0000,
  parameter [63:0] RIGHT_INIT = 64'h0000_0000_0000_0000
) (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire [1:0] i_mode,
  input wire [5:0] i_addr,
  input wire [5:0] i_read2_addr,
  input wire [3:0] i_right_inputs,
  input wire [2:0] i_wide_sel,
  input wire i_we,
  input wire i_data,
  input wire i_chain_serial_in,
  input wire i_in_valid,
  output reg o_in_ready,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg o_out_data,
  output reg o_out2,
  output reg o_chain_serial_out
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Bit select by a two-bit index, shared by the wide mux and the read paths
  function pick4;
    input [3:0] v;
    input [1:0] s;
    begin
      pick4 = v[s];
    end
  endfunction

  // Upper address bits pick the cell of the 64-deep memory
  function [1:0] cell_of;
    input [5:0] addr;
    begin
      cell_of = addr[5:4];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Cells
  // --------------------------------------------------------------------------
  wire [3:0] left_out;
  wire [3:0] left_out2;
  wire [3:0] right_out;
  wire [3:0] chain;
  wire [3:0] left_we;
  wire [3:0] chain_in;
  wire [3:0] shift_addr;
  wire [3:0] cell_addr;
  wire stall;

  // A full output buffer (o_in_ready low) freezes writes and the shift path so no word is dropped
  assign stall = !o_in_ready;
  assign chain_in = {chain[2:0], i_chain_serial_in};
  // Each cell is a full 16 stages when chained; the tap is read from the tap_r mirror
  assign shift_addr = 4'hf;
  assign cell_addr = (i_mode == `MODE_SHIFT) ? shift_addr : i_addr[3:0];

  genvar g;
  generate
    for (g = 0; g < `CLUSTER_CELLS; g = g + 1) begin : g_cells
      // Deeper memory: upper address bits select which cell takes the write
      assign left_we[g] = i_we && !stall && ((i_mode == `MODE_SHIFT) ||
                          (cell_of(i_addr) == g));
      lut_cell #(.INIT(LEFT_INIT[16*g +: 16]), .WRITABLE(1)) u_left (
        .i_ref_clk(i_ref_clk),
        .i_mode(i_mode),
        .i_lut_inputs(cell_addr),
        .i_read2_addr(i_read2_addr[3:0]),
        .i_we(left_we[g]),
        .i_data(i_data),
        .i_chain_serial_in(chain_in[g]),
        .o_out(left_out[g]),
        .o_out2(left_out2[g]),
        .o_chain_serial_out(chain[g])
      );
      lut_cell #(.INIT(RIGHT_INIT[16*g +: 16]), .WRITABLE(0)) u_right (
        .i_ref_clk(i_ref_clk),
        .i_mode(`MODE_LOGIC),
        .i_lut_inputs(i_right_inputs),
        .i_read2_addr(i_right_inputs),
        .i_we(i_we),
        .i_data(i_data),
        .i_chain_serial_in(1'b0),
        .o_out(right_out[g]),
        .o_out2(),
        .o_chain_serial_out()
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Shift tap: delay 1..64 picked from the tap_r mirror by i_addr
  // --------------------------------------------------------------------------
  reg [63:0] tap_r;
  wire tap_bit;
  wire shift_go;

  // Same shift enable as the cells; RAM-mode writes change the cascade but not the mirror
  assign shift_go = i_we && !stall && (i_mode == `MODE_SHIFT);

  // A mirror of the cascade, so any stage can be tapped combinationally
  always @(posedge i_ref_clk) begin
    if (shift_go) begin
      tap_r <= {tap_r[62:0], i_chain_serial_in};
    end
  end
  assign tap_bit = tap_r[i_addr];

  // --------------------------------------------------------------------------
  // Wide multiplexer and result select
  // --------------------------------------------------------------------------
  function mux8;
    input [3:0] a;
    input [3:0] b;
    input [2:0] s;
    begin
      mux8 = s[2] ? pick4(b, s[1:0]) : pick4(a, s[1:0]);
    end
  endfunction

  reg result;
  reg result2;
  always @* begin
    case (i_mode)
      `MODE_RAM: begin
        result = pick4(left_out, cell_of(i_addr));
        result2 = pick4(left_out2, cell_of(i_read2_addr));
      end
      `MODE_SHIFT: begin
        result = tap_bit;
        result2 = chain[3];
      end
      default: begin
        result = mux8(left_out, right_out, i_wide_sel);
        result2 = right_out[0];
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Two-entry output buffer
  // --------------------------------------------------------------------------
  // Head entry is o_out_data; buf_r holds the second word while the
  // receiver stalls, so ready drops only once both entries are taken
  reg buf_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_r <= `OUT_RST;
      cnt_r <= `BUF_CNT_RST;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
      o_out_data <= `OUT_RST;
      o_out2 <= `OUT_RST;
      o_chain_serial_out <= `OUT_RST;
    end else begin
      o_out2 <= result2;
      o_chain_serial_out <= chain[3];
      case ({push, pop})
        2'b10: begin
          if (cnt_r == 2'h0) begin
            o_out_data <= result;
          end else begin
            buf_r <= result;
          end
          cnt_r <= cnt_r + 2'h1;
          o_out_valid <= 1'b1;
          o_in_ready <= (cnt_r == 2'h0);
        end
        2'b01: begin
          o_out_data <= buf_r;
          cnt_r <= cnt_r - 2'h1;
          o_out_valid <= (cnt_r == 2'h2);
          o_in_ready <= 1'b1;
        end
        2'b11: begin
          if (cnt_r == 2'h1) begin
            o_out_data <= result;
          end else begin
            o_out_data <= buf_r;
            buf_r <= result;
          end
        end
        default: begin
          o_out_data <= o_out_data;
        end
      endcase
    end
  end

endmodule // lut_cluster

// ### bench/lut_cluster_monitor.sv
/* Checker for the cluster: buffer handshake, second read port, chain out.
   Assumes a bind onto lut_cluster, one clock and an async low reset. */
`include "lut_cell_map.vh"
module lut_cluster_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_mode,
  input wire logic [5:0] i_addr,
  input wire logic [5:0] i_read2_addr,
  input wire logic [3:0] i_right_inputs,
  input wire logic i_we,
  input wire logic i_data,
  input wire logic i_in_valid,
  input wire logic o_in_ready,
  input wire logic o_out_valid,
  input wire logic i_out_ready,
  input wire logic o_out_data,
  input wire logic o_out2,
  input wire logic o_chain_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic shf;
  assign take = i_in_valid && o_in_ready;
  // A refused enable must not count as a write or a shift
  assign shf = i_we && o_in_ready;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence calm;
    !shf && $stable(i_read2_addr) && $stable(i_mode) && $stable(i_right_inputs);
  endsequence
  a_push_valid: assert property (take |=> o_out_valid)
    else $error("valid missing after push");
  a_head_hold: assert property (o_out_valid && !i_out_ready
    |=> o_out_valid && $stable(o_out_data)) else $error("head changed while stalled");
  a_pop_frees: assert property (o_out_valid && i_out_ready && !take |=> o_in_ready)
    else $error("no room after pop");
  a_full_stays: assert property (!o_in_ready && !i_out_ready |=> !o_in_ready)
    else $error("room appeared without pop");
  a_idle_quiet: assert property (!o_out_valid && !take |=> !o_out_valid)
    else $error("valid without push");
  a_port2_hold: assert property (calm [*2] |=> $stable(o_out2))
    else $error("second port moved without write");
  a_chain_hold: assert property (calm [*2] |=> $stable(o_chain_serial_out))
    else $error("chain out moved without shift");
  a_ram_port2: assert property (i_mode == `MODE_RAM && shf && i_addr == i_read2_addr
    ##1 !shf && $stable(i_read2_addr) |=> o_out2 == $past(i_data, 2))
    else $error("second port misses written bit");
  c_full: cover property (!o_in_ready && i_in_valid);
  c_stall: cover property (o_out_valid && !i_out_ready);
  c_shift: cover property (i_mode == `MODE_SHIFT && shf);
endmodule // lut_cluster_monitor

bind lut_cluster lut_cluster_monitor i_lut_cluster_monitor (.*);

// ### bench/lut_sink.sv
/* Receiver model for the downstream user logic; queues every word taken.
   Assumes valid and ready are sampled on the rising clock edge. */
module lut_sink (
  input wire logic i_ref_clk,
  input wire logic i_valid,
  input wire logic i_data,
  input wire logic i_stall,
  output wire logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic q [$];
  // Stall is set by the bench to back-pressure the buffer
  assign o_ready = !i_stall;
  always @(posedge i_ref_clk) begin
    if (i_valid && o_ready) q.push_back(i_data);
  end
endmodule // lut_sink

// ### bench/tb_top.sv
/* Self-checking bench for the cluster: ROM, RAM, buffer and shift modes.
   Assumes lut_cluster, its bound checker and the lut_sink receiver. */
`include "lut_cell_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] ROM = 64'h9c3a_5f01_e7b2_46d8;
  logic i_ref_clk = 0, i_arst_n = 0, i_we = 0, i_data = 0, i_chain_serial_in = 0;
  logic i_in_valid = 0, stall = 0, o_in_ready, o_out_valid, i_out_ready, o_out_data;
  logic o_out2, o_chain_serial_out;
  logic [1:0] i_mode = 0;
  logic [5:0] i_addr = 0, i_read2_addr = 0;
  logic [3:0] i_right_inputs = 0;
  logic [2:0] i_wide_sel = 0;
  int miscompares = 0, checked = 0;
  lut_cluster #(.LEFT_INIT(64'h0000_0000_0000_0000), .RIGHT_INIT(ROM)) i_lut_cluster (.*);
  lut_sink i_lut_sink (.i_ref_clk, .i_valid(o_out_valid), .i_data(o_out_data),
    .i_stall(stall), .o_ready(i_out_ready));
  function automatic logic pat(int i);
    return i[0] ^ i[2] ^ (i % 5 == 0);
  endfunction
  function automatic logic take();
    return i_lut_sink.q.size() ? i_lut_sink.q.pop_front() : 1'bx;
  endfunction
  task automatic chk(string name, logic seen, logic exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic push;
    @(negedge i_ref_clk) i_in_valid = 1;
    for (int n = 0; n < 20; n++) begin
      @(posedge i_ref_clk);
      if (o_in_ready === 1'b1) break;
    end
    @(negedge i_ref_clk) i_in_valid = 0;
  endtask
  task automatic sample(string name, logic exp);
    push;
    for (int n = 0; n < 20 && i_lut_sink.q.size() == 0; n++) @(negedge i_ref_clk);
    chk(name, take(), exp);
  endtask
  task automatic t_rom(input bit loaded);
    i_mode = `MODE_LOGIC;
    for (int k = 0; k < 8; k++) begin
      for (int v = 0; v < 16; v++) begin
        i_wide_sel = 3'(k);
        i_right_inputs = 4'(v);
        i_addr = 6'(v);
        if (k < 4) sample("wide", loaded && pat(16 * k + v));
        else sample("rom", ROM[16 * (k - 4) + v]);
        chk("rom port2", o_out2, ROM[v]);
      end
    end
  endtask
  task automatic t_ram;
    i_mode = `MODE_RAM;
    for (int a = 0; a < 64; a++) begin
      @(negedge i_ref_clk);
      i_addr = 6'(a);
      i_read2_addr = 6'(a);
      i_data = pat(a);
      i_we = 1;
      @(negedge i_ref_clk);
      i_we = 0;
      i_data = !pat(a);
    end
    for (int a = 0; a < 64; a++) begin
      i_addr = 6'(a);
      i_read2_addr = 6'(63 - a);
      sample("ram", pat(a));
      chk("port2", o_out2, pat(63 - a));
    end
  endtask
  task automatic t_buf;
    i_mode = `MODE_RAM;
    stall = 1;
    i_addr = 6'd1;
    push;
    i_addr = 6'd2;
    push;
    chk("full", o_in_ready, 1'b0);
    chk("held", o_out_valid, 1'b1);
    // Write while full must be refused
    i_data = !pat(2);
    i_we = 1;
    @(negedge i_ref_clk) i_we = 0;
    stall = 0;
    for (int n = 0; n < 20 && i_lut_sink.q.size() < 2; n++) @(negedge i_ref_clk);
    chk("first", take(), pat(1));
    chk("second", take(), pat(2));
    chk("drained", o_out_valid, 1'b0);
    sample("refused", pat(2));
  endtask
  task automatic t_reset;
    stall = 1;
    i_addr = 6'd3;
    push;
    chk("valid", o_out_valid, 1'b1);
    i_arst_n = 0;
    @(negedge i_ref_clk);
    chk("reset valid", o_out_valid, `OUT_RST);
    chk("reset ready", o_in_ready, 1'b1);
    chk("reset data", o_out_data, `OUT_RST);
    chk("reset port2", o_out2, `OUT_RST);
    chk("reset chain", o_chain_serial_out, `OUT_RST);
    i_arst_n = 1;
    stall = 0;
    repeat (3) @(negedge i_ref_clk);
    chk("flushed", i_lut_sink.q.size() == 0, 1'b1);
    sample("kept", pat(3));
  endtask
  task automatic t_shift;
    int taps[6] = '{0, 1, 15, 16, 47, 63};
    i_mode = `MODE_SHIFT;
    for (int i = 0; i < 70; i++) begin
      @(negedge i_ref_clk);
      i_chain_serial_in = pat(i);
      i_we = 1;
    end
    @(negedge i_ref_clk);
    i_we = 0;
    i_chain_serial_in = !pat(69);
    foreach (taps[j]) begin
      i_addr = 6'(taps[j]);
      sample("tap", pat(69 - taps[j]));
    end
    chk("chain", o_chain_serial_out, pat(6));
    chk("shift port2", o_out2, pat(6));
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #20 i_ref_clk = !i_ref_clk;
  initial begin
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk) i_arst_n = 1;
    t_rom(1'b0);
    t_ram;
    t_rom(1'b1);
    t_buf;
    t_reset;
    t_shift;
    report_and_stop;
  end
  // Normal run is near 1200 cycles; allow about eight times that
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
endmodule // tb_top
